// File: design/otseq_pkg.sv
// Constants, field layouts and carrier types of the output transient sequencer.
// Assumes one clock domain at 50 MHz; all users import the whole package.
package otseq_pkg;

   // List storage and step addressing
   localparam int LIST_DEPTH = 100;
   localparam int STEP_AW = 7;
   localparam logic [6:0] STEP_FIRST = 7'h00;
   localparam logic [6:0] STEP_MAX = 7'h63;
   localparam logic [6:0] EVENT_MIN = 7'h01;
   localparam logic [6:0] EVENT_MAX = 7'h63;

   // Field widths
   localparam int LEVEL_W = 16;
   localparam int DUR_W = 16;
   localparam int TIME_W = 40;
   localparam int CYC_W = 24;
   localparam int PHASE_W = 9;
   localparam int WAVE_W = 6;
   localparam int REP_W = 8;

   // Waveshape codes: standard shapes first, then the user library
   localparam int STD_WAVES = 3;
   localparam int USER_WAVES = 50;
   localparam logic [5:0] WAVE_SINE = 6'h00;
   localparam logic [5:0] WAVE_LAST = 6'(STD_WAVES + USER_WAVES - 1);

   // Timing: durations in seconds mode are counted in milliseconds
   localparam int CLK_PERIOD_NS = 20;
   localparam int MS_NS = 1000000;
   localparam int CLK_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;

   // Positions of the field-supplied flags in a write request
   localparam int GV_EXC = 0;
   localparam int GV_FIN = 1;
   localparam int GV_DUR = 2;
   localparam int GV_HOLD = 3;
   localparam int GV_EVT = 4;
   localparam int GV_W = 5;

   typedef enum logic [2:0] {
      OTSEQ_KIND_SURGE,
      OTSEQ_KIND_VSWEEP,
      OTSEQ_KIND_FSWEEP,
      OTSEQ_KIND_VF_VOLT,
      OTSEQ_KIND_VF_FREQ
   } otseq_kind_t;

   typedef enum logic {
      OTSEQ_UNIT_SEC,
      OTSEQ_UNIT_CYC
   } otseq_unit_t;

   // One stored list entry
   typedef struct packed {
      otseq_kind_t kind;
      logic phase_on;
      logic [PHASE_W-1:0] phase;
      logic [LEVEL_W-1:0] excursion_level;
      logic [LEVEL_W-1:0] final_level;
      logic [DUR_W-1:0] duration;
      logic [DUR_W-1:0] hold;
      otseq_unit_t duration_unit;
      logic [WAVE_W-1:0] wave;
      logic [REP_W-1:0] repeat_cnt;
      logic [6:0] event_num;
   } otseq_entry_t;

   localparam int ENTRY_W = $bits(otseq_entry_t);

   // Write request from the configuring side
   typedef struct packed {
      otseq_entry_t entry;
      logic [LEVEL_W-1:0] freq_final;
      logic [GV_W-1:0] given;
   } otseq_wreq_t;

   typedef struct packed {
      logic [LEVEL_W-1:0] amp;
      logic [LEVEL_W-1:0] freq;
   } otseq_lvl_t;

   typedef struct packed {
      logic [LEVEL_W-1:0] amp;
      logic [LEVEL_W-1:0] freq;
      logic [WAVE_W-1:0] wave;
   } otseq_out_t;

endpackage

// File: design/otseq_mem.sv
// Step list storage with a defined flag per slot and registered read data.
// Assumes the caller never writes and clears the same slot in one cycle.
`timescale 1ns/1ns
module otseq_mem #(
   parameter int W = 8,
   parameter int DEPTH = 100,
   parameter int AW = 7
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic clr_en,
   input wire logic [AW-1:0] clr_addr,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data,
   output logic rd_def
);
   logic [W-1:0] mem [DEPTH];
   logic [DEPTH-1:0] def_ff, nxt_def;

   // Defined flags: a write sets, an erase clears, the write wins
   always_comb begin
      nxt_def = def_ff;
      if (clr_en && int'(clr_addr) < DEPTH) nxt_def[clr_addr] = 1'b0;
      if (wr_en && int'(wr_addr) < DEPTH) nxt_def[wr_addr] = 1'b1;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) def_ff <= '0;
      else def_ff <= nxt_def;
   end

   // Array write and registered read; out of range reads as undefined
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= '0;
         rd_def <= 1'b0;
      end else begin
         if (int'(rd_addr) < DEPTH) rd_data <= mem[rd_addr];
         rd_def <= (int'(rd_addr) < DEPTH) ? def_ff[rd_addr] : 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (wr_en && int'(wr_addr) < DEPTH) mem[wr_addr] <= wr_data;
   end
endmodule

// File: design/otseq_ramp.sv
// Level generator: jumps or ramps linearly to a target over a cycle count.
// Assumes one unit of level per clock at most; the end value is forced.
`timescale 1ns/1ns
module otseq_ramp #(
   parameter int W = 16,
   parameter int TW = 40
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic preset,
   input wire logic [W-1:0] preset_val,
   input wire logic load,
   input wire logic [W-1:0] target,
   input wire logic [TW-1:0] total,
   output logic [W-1:0] value
);
   logic [W-1:0] val_ff, nxt_val, tgt_ff, nxt_tgt, dist_ff, nxt_dist;
   logic [TW-1:0] tot_ff, nxt_tot, cnt_ff, nxt_cnt;
   logic [TW:0] acc_ff, nxt_acc, sum;
   logic act_ff, nxt_act, up_ff, nxt_up;

   assign sum = acc_ff + (TW+1)'(dist_ff);
   assign value = val_ff;

   // Error-accumulating walk spreads the distance evenly over the count
   always_comb begin
      nxt_val = val_ff;
      nxt_tgt = tgt_ff;
      nxt_dist = dist_ff;
      nxt_tot = tot_ff;
      nxt_cnt = cnt_ff;
      nxt_acc = acc_ff;
      nxt_act = act_ff;
      nxt_up = up_ff;
      if (preset) begin
         nxt_val = preset_val;
         nxt_act = 1'b0;
      end else if (load) begin
         nxt_tgt = target;
         if (total == '0) begin
            nxt_val = target;
            nxt_act = 1'b0;
         end else begin
            nxt_act = 1'b1;
            nxt_tot = total;
            nxt_cnt = total;
            nxt_acc = '0;
            nxt_up = target > val_ff;
            nxt_dist = (target > val_ff) ? target - val_ff : val_ff - target;
         end
      end else if (act_ff) begin
         nxt_cnt = cnt_ff - 1'b1;
         if (cnt_ff == TW'(1)) begin
            nxt_val = tgt_ff;
            nxt_act = 1'b0;
         end else if (sum >= {1'b0, tot_ff}) begin
            nxt_acc = sum - {1'b0, tot_ff};
            nxt_val = up_ff ? val_ff + 1'b1 : val_ff - 1'b1;
         end else begin
            nxt_acc = sum;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         val_ff <= '0;
         tgt_ff <= '0;
         dist_ff <= '0;
         tot_ff <= '0;
         cnt_ff <= '0;
         acc_ff <= '0;
         act_ff <= 1'b0;
         up_ff <= 1'b0;
      end else begin
         val_ff <= nxt_val;
         tgt_ff <= nxt_tgt;
         dist_ff <= nxt_dist;
         tot_ff <= nxt_tot;
         cnt_ff <= nxt_cnt;
         acc_ff <= nxt_acc;
         act_ff <= nxt_act;
         up_ff <= nxt_up;
      end
   end
endmodule

// File: design/otseq_top.sv
// Output transient sequencer: step list entry, list walk and level control.
// Assumes all inputs come from logic on clk_sys; the menu side writes steps.
`timescale 1ns/1ns
module otseq_top import otseq_pkg::*; #(
   parameter int CLK_PER_MS = CLK_PER_MS_DEF
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [STEP_AW-1:0] wr_addr,
   input wire otseq_wreq_t wr_req,
   input wire logic erase_en,
   input wire logic [STEP_AW-1:0] erase_addr,
   output logic wr_ready,
   output logic wr_ok,
   output logic wr_err,
   input wire logic start,
   input wire logic dc_mode,
   input wire logic [PHASE_W-1:0] phase_now,
   input wire logic [CYC_W-1:0] cycle_clocks,
   input wire logic level_load,
   input wire otseq_lvl_t idle_level,
   output logic busy,
   output logic seq_done,
   output logic [STEP_AW-1:0] cur_step,
   output logic [6:0] cur_event,
   output otseq_out_t out_now
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_READ, ST_LATCH, ST_PAIR_RD, ST_PAIR_LT, ST_PHASE,
      ST_APPLY, ST_DWELL, ST_MOVE, ST_HOLD, ST_NEXT
   } otseq_state_t;

   otseq_state_t state_ff, nxt_state;
   logic [STEP_AW-1:0] addr_ff, nxt_addr;
   otseq_entry_t cur_ff, nxt_cur;
   logic [LEVEL_W-1:0] ftgt_ff, nxt_ftgt;
   logic [REP_W-1:0] rep_ff, nxt_rep;
   logic [TIME_W-1:0] time_ff, nxt_time, dur_clk, hold_clk;
   logic first_ff, nxt_first, done_ff, nxt_done;
   logic [WAVE_W-1:0] wave_ff, nxt_wave;
   logic [STEP_AW:0] next_addr;
   logic a_load, f_load;
   logic [LEVEL_W-1:0] a_tgt, f_tgt, a_val, f_val;
   logic [TIME_W-1:0] a_tot, f_tot;
   logic [STEP_AW-1:0] rd_addr, mem_wa;
   logic [ENTRY_W-1:0] rd_data;
   otseq_entry_t rd_ent, mem_wd, wentry;
   logic rd_def, mem_we, accept, req_good;
   logic pend_ff, nxt_pend, ok_ff, nxt_ok, err_ff, nxt_err;
   logic [STEP_AW-1:0] paddr_ff, nxt_paddr;
   otseq_entry_t pdata_ff, nxt_pdata;

   // Duration count in clocks; the unit selects ms or output periods
   function automatic logic [TIME_W-1:0] to_clk(input logic [DUR_W-1:0] d,
                                                input otseq_unit_t u,
                                                input logic [CYC_W-1:0] cyc);
      logic [CYC_W-1:0] base;
      base = (u == OTSEQ_UNIT_SEC) ? CYC_W'(CLK_PER_MS) : cyc;
      return TIME_W'(d) * TIME_W'(base);
   endfunction

   // Checks of a write request against slot and field limits
   function automatic logic req_check(input otseq_wreq_t r,
                                      input logic [STEP_AW-1:0] a);
      logic need_exc;
      need_exc = (r.entry.kind == OTSEQ_KIND_SURGE);
      return r.given[GV_FIN] && r.given[GV_DUR] && r.given[GV_HOLD]
         && r.given[GV_EVT] && (r.given[GV_EXC] || !need_exc)
         && r.entry.event_num >= EVENT_MIN && r.entry.event_num <= EVENT_MAX
         && r.entry.wave <= WAVE_LAST
         && a <= STEP_MAX
         && !(r.entry.kind == OTSEQ_KIND_VF_VOLT && a == STEP_MAX)
         && r.entry.kind <= OTSEQ_KIND_VF_VOLT;
   endfunction

   assign dur_clk = to_clk(cur_ff.duration, cur_ff.duration_unit, cycle_clocks);
   assign hold_clk = to_clk(cur_ff.hold, cur_ff.duration_unit, cycle_clocks);
   assign rd_ent = otseq_entry_t'(rd_data);
   assign next_addr = {1'b0, addr_ff}
      + ((cur_ff.kind == OTSEQ_KIND_VF_VOLT) ? (STEP_AW+1)'(2) : (STEP_AW+1)'(1));
   assign rd_addr = (state_ff == ST_PAIR_RD) ? addr_ff + 1'b1 : addr_ff;
   assign busy = (state_ff != ST_IDLE);
   assign seq_done = done_ff;
   assign cur_step = addr_ff;
   assign cur_event = cur_ff.event_num;
   assign out_now = '{amp: a_val, freq: f_val, wave: wave_ff};
   assign wr_ready = !pend_ff && (state_ff == ST_IDLE);
   assign wr_ok = ok_ff;
   assign wr_err = err_ff;
   assign accept = wr_en && wr_ready;
   assign req_good = req_check(wr_req, wr_addr);

   // Step entry: phase stripped off-slot-0 or for DC, pair written second
   always_comb begin
      wentry = wr_req.entry;
      if (wr_addr != STEP_FIRST || dc_mode) wentry.phase_on = 1'b0;
      nxt_pend = 1'b0;
      nxt_paddr = paddr_ff;
      nxt_pdata = pdata_ff;
      nxt_ok = accept && req_good;
      nxt_err = accept && !req_good;
      if (accept && req_good && wentry.kind == OTSEQ_KIND_VF_VOLT) begin
         nxt_pend = 1'b1;
         nxt_paddr = wr_addr + 1'b1;
         nxt_pdata = wentry;
         nxt_pdata.kind = OTSEQ_KIND_VF_FREQ;
         nxt_pdata.final_level = wr_req.freq_final;
         nxt_pdata.phase_on = 1'b0;
      end
      mem_we = (accept && req_good) || pend_ff;
      mem_wa = pend_ff ? paddr_ff : wr_addr;
      mem_wd = pend_ff ? pdata_ff : wentry;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pend_ff <= 1'b0;
         paddr_ff <= '0;
         pdata_ff <= '0;
         ok_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         pend_ff <= nxt_pend;
         paddr_ff <= nxt_paddr;
         pdata_ff <= nxt_pdata;
         ok_ff <= nxt_ok;
         err_ff <= nxt_err;
      end
   end

   // List walk and per-step timing
   always_comb begin
      nxt_state = state_ff;
      nxt_addr = addr_ff;
      nxt_cur = cur_ff;
      nxt_ftgt = ftgt_ff;
      nxt_rep = rep_ff;
      nxt_time = (time_ff != '0) ? time_ff - 1'b1 : time_ff;
      nxt_first = first_ff;
      nxt_wave = wave_ff;
      nxt_done = 1'b0;
      a_load = 1'b0;
      a_tgt = cur_ff.final_level;
      a_tot = '0;
      f_load = 1'b0;
      f_tgt = ftgt_ff;
      f_tot = '0;
      case (state_ff)
         ST_IDLE: if (start) begin
            nxt_addr = STEP_FIRST;
            nxt_first = 1'b1;
            nxt_state = ST_READ;
         end
         ST_READ: nxt_state = ST_LATCH;
         ST_LATCH: if (!rd_def || rd_ent.kind == OTSEQ_KIND_VF_FREQ) begin
            if (addr_ff == STEP_MAX) begin
               nxt_done = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               nxt_addr = addr_ff + 1'b1;
               nxt_state = ST_READ;
            end
         end else begin
            nxt_cur = rd_ent;
            nxt_rep = rd_ent.repeat_cnt;
            nxt_ftgt = (rd_ent.kind == OTSEQ_KIND_FSWEEP) ? rd_ent.final_level : f_val;
            nxt_state = (rd_ent.kind == OTSEQ_KIND_VF_VOLT) ? ST_PAIR_RD : ST_PHASE;
         end
         ST_PAIR_RD: nxt_state = ST_PAIR_LT;
         ST_PAIR_LT: begin
            if (rd_def && rd_ent.kind == OTSEQ_KIND_VF_FREQ) nxt_ftgt = rd_ent.final_level;
            nxt_state = ST_PHASE;
         end
         ST_PHASE: if (!first_ff || !cur_ff.phase_on || dc_mode
                       || phase_now == cur_ff.phase) begin
            nxt_first = 1'b0;
            nxt_state = ST_APPLY;
         end
         ST_APPLY: begin
            nxt_wave = cur_ff.wave;
            nxt_time = dur_clk;
            if (cur_ff.kind == OTSEQ_KIND_SURGE) begin
               a_load = 1'b1;
               a_tgt = cur_ff.excursion_level;
               nxt_state = ST_DWELL;
            end else begin
               a_load = (cur_ff.kind != OTSEQ_KIND_FSWEEP);
               a_tot = dur_clk;
               f_load = (cur_ff.kind != OTSEQ_KIND_VSWEEP);
               f_tot = dur_clk;
               nxt_state = ST_MOVE;
            end
         end
         ST_DWELL: if (time_ff == '0) begin
            a_load = 1'b1;
            nxt_time = hold_clk;
            nxt_state = ST_HOLD;
         end
         ST_MOVE: if (time_ff == '0) begin
            nxt_time = hold_clk;
            nxt_state = ST_HOLD;
         end
         ST_HOLD: if (time_ff == '0) begin
            if (rep_ff != '0) begin
               nxt_rep = rep_ff - 1'b1;
               nxt_state = ST_APPLY;
            end else begin
               nxt_state = ST_NEXT;
            end
         end
         ST_NEXT: if (next_addr > {1'b0, STEP_MAX}) begin
            nxt_done = 1'b1;
            nxt_state = ST_IDLE;
         end else begin
            nxt_addr = next_addr[STEP_AW-1:0];
            nxt_state = ST_READ;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_IDLE;
         addr_ff <= STEP_FIRST;
         cur_ff <= '0;
         ftgt_ff <= '0;
         rep_ff <= '0;
         time_ff <= '0;
         first_ff <= 1'b0;
         wave_ff <= WAVE_SINE;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         addr_ff <= nxt_addr;
         cur_ff <= nxt_cur;
         ftgt_ff <= nxt_ftgt;
         rep_ff <= nxt_rep;
         time_ff <= nxt_time;
         first_ff <= nxt_first;
         wave_ff <= nxt_wave;
         done_ff <= nxt_done;
      end
   end

   // List storage of 100 slots
   otseq_mem #(.W(ENTRY_W), .DEPTH(LIST_DEPTH), .AW(STEP_AW)) u_list (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .wr_en(mem_we),
      .wr_addr(mem_wa),
      .wr_data(mem_wd),
      .clr_en(erase_en && wr_ready),
      .clr_addr(erase_addr),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_def(rd_def)
   );

   // Amplitude and frequency generators
   otseq_ramp #(.W(LEVEL_W), .TW(TIME_W)) u_amp (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .preset(level_load && !busy),
      .preset_val(idle_level.amp),
      .load(a_load),
      .target(a_tgt),
      .total(a_tot),
      .value(a_val)
   );

   otseq_ramp #(.W(LEVEL_W), .TW(TIME_W)) u_freq (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .preset(level_load && !busy),
      .preset_val(idle_level.freq),
      .load(f_load),
      .target(f_tgt),
      .total(f_tot),
      .value(f_val)
   );

   // Checks of walk, timing and entry behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   addr_range_a: assert property (busy |-> addr_ff <= STEP_MAX)
      else $error("step address beyond last slot");
   skip_undef_a: assert property (state_ff == ST_LATCH && !rd_def && addr_ff != STEP_MAX
      |=> state_ff == ST_READ && addr_ff == $past(addr_ff) + 1'b1)
      else $error("undefined slot not skipped");
   surge_exc_a: assert property (state_ff == ST_APPLY && cur_ff.kind == OTSEQ_KIND_SURGE
      |=> a_val == $past(cur_ff.excursion_level))
      else $error("excursion level not applied");
   vstep_now_a: assert property (state_ff == ST_APPLY && cur_ff.kind == OTSEQ_KIND_VSWEEP
      && dur_clk == '0 |=> a_val == $past(cur_ff.final_level))
      else $error("voltage step not immediate");
   wave_entry_a: assert property (state_ff == ST_APPLY
      |=> wave_ff == $past(cur_ff.wave) ##1 $stable(wave_ff))
      else $error("waveshape not switched on entry");
   hold_wait_a: assert property (state_ff == ST_HOLD && time_ff > TIME_W'(1)
      |=> state_ff == ST_HOLD [*2])
      else $error("hold left early");
   repeat_cnt_a: assert property (state_ff == ST_HOLD && time_ff == '0 && rep_ff != '0
      |=> state_ff == ST_APPLY && rep_ff == $past(rep_ff) - 1'b1)
      else $error("repeat not counted");
   phase_wait_a: assert property (state_ff == ST_PHASE && first_ff && cur_ff.phase_on
      && !dc_mode && phase_now != cur_ff.phase |=> state_ff == ST_PHASE)
      else $error("start phase not awaited");
   bad_entry_a: assert property (accept && !wr_req.given[GV_EVT]
      |=> wr_err && !wr_ok ##1 (wr_err == $past(accept && !req_good)))
      else $error("incomplete entry not refused");
   pair_write_a: assert property (accept && req_good && wr_req.entry.kind == OTSEQ_KIND_VF_VOLT
      |=> mem_we && mem_wa == $past(wr_addr) + 1'b1 && !wr_ready)
      else $error("combined step pair not written");

   seq_end_c: cover property (state_ff == ST_NEXT ##1 seq_done);
   pair_run_c: cover property (state_ff == ST_PAIR_LT ##1 state_ff == ST_PHASE);
   repeat_c: cover property (state_ff == ST_HOLD ##1 state_ff == ST_APPLY);
endmodule

// File: test/otseq_menu.sv
// Front-panel menu model: enters list entries through the write port and erases them through the erase port.
// Assumes the bench calls its tasks from one process and only while the list is idle.
`timescale 1ns/1ns
module otseq_menu import otseq_pkg::*; (
   input wire logic clk_sys,
   input wire logic wr_ok,
   input wire logic wr_err,
   output logic wr_en,
   output logic [STEP_AW-1:0] wr_addr,
   output otseq_wreq_t wr_req,
   output logic erase_en,
   output logic [STEP_AW-1:0] erase_addr
);
   // Idle values at time zero
   initial begin
      wr_en = 1'b0;
      wr_addr = 7'h00;
      wr_req = '0;
      erase_en = 1'b0;
      erase_addr = 7'h00;
   end

   // One entry, held to the taking edge; the answer is read just after it
   task automatic put(input logic [6:0] a, input otseq_wreq_t r, output logic ok,
                      output logic err);
      @(posedge clk_sys);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_req <= r; // Fields are supplied by the caller
      @(posedge clk_sys);
      wr_en <= 1'b0;
      wr_req <= ~r; // Released fields stop showing the last value
      wr_addr <= ~a;
      #1;
      ok = wr_ok;
      err = wr_err;
   endtask

   // Clear one slot with a single-cycle request
   task automatic erase(input logic [6:0] a);
      @(posedge clk_sys);
      erase_en <= 1'b1;
      erase_addr <= a;
      @(posedge clk_sys);
      erase_en <= 1'b0;
   endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench: fills the list, walks it and compares the level trace.
// Assumes the menu model drives the write port; CLK_PER_MS is shortened to 5.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top import otseq_pkg::*;;
   logic clk_sys, rst_b, wr_en, erase_en, wr_ready, wr_ok, wr_err, start, level_load, busy;
   logic seq_done, ok, err, dc_mode;
   logic [STEP_AW-1:0] cur_step;
   logic [6:0] cur_event;
   logic [STEP_AW-1:0] wr_addr, erase_addr;
   logic [PHASE_W-1:0] phase_now;
   otseq_wreq_t wr_req, r;
   otseq_lvl_t idle_level, prev;
   otseq_lvl_t lv_log[$];
   otseq_lvl_t lv_exp[10];
   otseq_out_t out_now;
   int bad_count = 0;
   int tests_run = 0;

   otseq_top #(.CLK_PER_MS(5)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_req(wr_req), .erase_en(erase_en), .erase_addr(erase_addr),
      .wr_ready(wr_ready), .wr_ok(wr_ok), .wr_err(wr_err), .start(start), .dc_mode(dc_mode),
      .phase_now(phase_now), .cycle_clocks(24'h000004), .level_load(level_load),
      .idle_level(idle_level), .busy(busy), .seq_done(seq_done), .cur_step(cur_step),
      .cur_event(cur_event), .out_now(out_now));
   otseq_menu menu (.clk_sys(clk_sys), .wr_ok(wr_ok), .wr_err(wr_err), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_req(wr_req), .erase_en(erase_en), .erase_addr(erase_addr));

   // Clock and a free-running output phase in degrees
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      phase_now <= (!rst_b || phase_now == 9'h167) ? 9'h000 : phase_now + 9'h001;
   end

   // Every change of amplitude or frequency is logged, sampled where settled
   always @(negedge clk_sys) begin
      if (rst_b && {out_now.amp, out_now.freq} !== prev) begin
         prev = {out_now.amp, out_now.freq};
         lv_log.push_back(prev);
      end
   end

   function automatic otseq_wreq_t mk(otseq_kind_t k, logic [15:0] exc, logic [15:0] fin,
         logic [15:0] ff, logic [15:0] dur, otseq_unit_t u, logic [5:0] w, logic [6:0] ev);
      otseq_wreq_t q;
      q = '0;
      q.entry.kind = k;
      q.entry.excursion_level = exc;
      q.entry.final_level = fin;
      q.freq_final = ff;
      q.entry.duration = dur;
      q.entry.hold = 16'h0001;
      q.entry.duration_unit = u;
      q.entry.wave = w;
      q.entry.event_num = ev;
      q.given = 5'h1F; // All mandatory fields supplied
      return q;
   endfunction

   // One write with the expected verdict
   task automatic try(input logic [6:0] a, input otseq_wreq_t q, input logic bad);
      menu.put(a, q, ok, err);
      `CHK("wr_err", bad, err)
      `CHK("wr_ok", ~bad, ok)
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog, well beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      final_report();
   end

   // Main sequence
   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      start = 1'b0;
      level_load = 1'b0;
      idle_level = '0;
      dc_mode = 1'b0;
      prev = '0;
      lv_exp = '{32'h00100020, 32'h01000020, 32'h00800020, 32'h01000020, 32'h00800020,
                 32'h02000020, 32'h03000400, 32'h03000500, 32'h06000500, 32'h07000500};
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1;
      `CHK("ready", 1'b1, wr_ready)
      `CHK("wave", WAVE_SINE, out_now.wave)
      r = mk(OTSEQ_KIND_SURGE, 16'h0600, 16'h0700, 16'h0, 16'h0002, OTSEQ_UNIT_SEC, 6'h02, 7'h63);
      try(7'h64, r, 1'b1);
      r.given = 5'h0F;
      try(7'h00, r, 1'b1);
      r.given = 5'h1F;
      r.entry.event_num = 7'h00;
      try(7'h00, r, 1'b1);
      r.entry.event_num = 7'h63;
      r.entry.wave = 6'h35;
      try(7'h00, r, 1'b1);
      r.entry.wave = 6'h34;
      try(7'h63, r, 1'b0);
      try(7'h63, mk(OTSEQ_KIND_VF_VOLT, 0, 16'h0300, 16'h0400, 0, OTSEQ_UNIT_SEC, 0, 7'h09),
          1'b1);
      r = mk(OTSEQ_KIND_SURGE, 16'h0100, 16'h0080, 16'h0, 16'h0002, OTSEQ_UNIT_SEC, 6'h05, 7'h01);
      r.entry.repeat_cnt = 8'h01;
      r.entry.phase_on = 1'b1;
      r.entry.phase = 9'h05A;
      try(7'h00, r, 1'b0);
      try(7'h03, mk(OTSEQ_KIND_VSWEEP, 0, 16'h0200, 0, 0, OTSEQ_UNIT_CYC, 6'h01, 7'h05),
          1'b0);
      try(7'h0A, mk(OTSEQ_KIND_VF_VOLT, 0, 16'h0300, 16'h0400, 0, OTSEQ_UNIT_SEC, 0, 7'h0A),
          1'b0);
      `CHK("ready after pair", 1'b0, wr_ready)
      try(7'h14, mk(OTSEQ_KIND_FSWEEP, 0, 16'h0500, 0, 0, OTSEQ_UNIT_SEC, 0, 7'h14),
          1'b0);
      try(7'h32, mk(OTSEQ_KIND_SURGE, 16'h0777, 16'h0777, 0, 1, OTSEQ_UNIT_SEC, 0, 7'h32),
          1'b0);
      menu.erase(7'h32);
      @(posedge clk_sys);
      level_load <= 1'b1;
      idle_level <= 32'h00100020;
      @(posedge clk_sys);
      level_load <= 1'b0;
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      #1;
      `CHK("busy", 1'b1, busy)
      for (int i = 0; i < 5000 && seq_done !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      `CHK("seq_done", 1'b1, seq_done)
      `CHK("busy at end", 1'b0, busy)
      `CHK("end wave", 6'h34, out_now.wave)
      `CHK("last step", STEP_MAX, cur_step)
      `CHK("last event", 7'h63, cur_event)
      `CHK("changes", 10, lv_log.size())
      for (int i = 0; i < 10 && i < lv_log.size(); i++)
         `CHK("level", lv_exp[i], lv_log[i])
      // Rerun on a DC output: slot 0 must not wait for its start phase
      @(posedge clk_sys);
      dc_mode <= 1'b1;
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("dc start", 16'h0100, out_now.amp)
      final_report();
   end
endmodule
